// ### hdl/bcc_pkg.sv
// Constants for the BCD calendar clock with alarm
package bcc_pkg;
	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [5:0] OFS_CONTROL = 6'h00;
	localparam logic [5:0] OFS_MODE = 6'h04;
	localparam logic [5:0] OFS_TIME = 6'h08;
	localparam logic [5:0] OFS_CAL = 6'h0C;
	localparam logic [5:0] OFS_TALARM = 6'h10;
	localparam logic [5:0] OFS_CALARM = 6'h14;
	localparam logic [5:0] OFS_STATUS = 6'h18;
	localparam logic [5:0] OFS_SCLEAR = 6'h1C;
	localparam logic [5:0] OFS_IRQ_EN = 6'h20;
	localparam logic [5:0] OFS_IRQ_DIS = 6'h24;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h28;
	localparam logic [5:0] OFS_VALIDITY = 6'h2C;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTL_UPD_TIM = 0;
	localparam int CTL_UPD_CAL = 1;
	localparam int CTL_TEV_LO = 8;
	localparam int CTL_CEV_LO = 16;
	localparam int MODE_HR12 = 0;
	localparam int TIM_MIN_LO = 8;
	localparam int TIM_HOUR_LO = 16;
	localparam int TIM_PM = 22;
	localparam int TAL_SEC_EN = 7;
	localparam int TAL_MIN_EN = 15;
	localparam int TAL_HOUR_EN = 23;
	localparam int CAL_YEAR_LO = 8;
	localparam int CAL_MONTH_LO = 16;
	localparam int CAL_DAY_LO = 21;
	localparam int CAL_DATE_LO = 24;
	localparam int CAL_MTH_EN = 23;
	localparam int CAL_DATE_EN = 31;
	// Status, clear and interrupt mask bit positions
	localparam int ST_ACK = 0;
	localparam int ST_ALARM = 1;
	localparam int ST_SEC = 2;
	localparam int ST_TEV = 3;
	localparam int ST_CEV = 4;
	localparam int ST_W = 5;
	// Validity flag positions
	localparam int VE_TIME = 0;
	localparam int VE_CAL = 1;
	localparam int VE_TALARM = 2;
	localparam int VE_CALARM = 3;
	localparam int VE_W = 4;
	// ---------------------------------------------------------------
	// Reset values and timing
	// ---------------------------------------------------------------
	localparam logic [31:0] RST_CAL = 32'h0181_9819;
	localparam logic [31:0] RST_CALARM = 32'h0101_0000;
	localparam int SLOW_CLOCK_HZ = 32768;
endpackage

// ### hdl/bcc_rtc.sv
// BCD time-of-day clock and calendar with alarm, events and entry checks
`timescale 1ns/1ps
`default_nettype none
module bcc_rtc #(
	parameter int TICKS_PER_SEC = bcc_pkg::SLOW_CLOCK_HZ
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic slow_ref_clock,
	input wire logic [5:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq
);
	localparam int CW = $clog2(TICKS_PER_SEC);

	// ---------------------------------------------------------------
	// Parameter check
	// ---------------------------------------------------------------
	if (TICKS_PER_SEC < 2) begin : g_bad_ticks
		$error("TICKS_PER_SEC must be at least 2");
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0] slk;
		logic [CW-1:0] div;
		logic tick_d;
		logic upd_tim;
		logic upd_cal;
		logic [1:0] tev_sel;
		logic [1:0] cev_sel;
		logic hr12;
		logic [6:0] sec;
		logic [6:0] min;
		logic [5:0] hour;
		logic [6:0] cent;
		logic [7:0] year;
		logic [4:0] month;
		logic [2:0] day;
		logic [5:0] date;
		logic [31:0] talarm;
		logic [31:0] calarm;
		logic [bcc_pkg::ST_W-1:0] status;
		logic [bcc_pkg::ST_W-1:0] mask;
		logic [bcc_pkg::VE_W-1:0] verr;
		logic [31:0] rdata;
	} bcc_state_t;

	bcc_state_t state_reg;
	bcc_state_t state_next;

	// ---------------------------------------------------------------
	// BCD helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] bcd2bin(input logic [7:0] b);
		return 8'(b[7:4]) * 8'h0A + 8'(b[3:0]);
	endfunction

	function automatic logic [7:0] bin2bcd(input logic [7:0] v);
		return {4'(v / 8'h0A), 4'(v % 8'h0A)};
	endfunction

	function automatic logic bcd_ok(input logic [7:0] b);
		return (b[3:0] <= 4'h9) && (b[7:4] <= 4'h9);
	endfunction

	// Days in month, leap every fourth year
	function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
		logic [7:0] d;
		d = 8'h1F;
		unique case (mon)
			8'h04, 8'h06, 8'h09, 8'h0B: d = 8'h1E;
			8'h02: d = (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
			default: d = 8'h1F;
		endcase
		return d;
	endfunction

	// Hour entry check by mode and PM indicator
	function automatic logic hour_ok(input logic [5:0] h, input logic pm, input logic hr12);
		logic [7:0] hb;
		hb = bcd2bin({2'h0, h});
		if (!bcd_ok({2'h0, h}))
			return 1'b0;
		else if (hr12)
			return (hb >= 8'h01) && (hb <= 8'h0C);
		else
			return !pm && (hb <= 8'h17);
	endfunction

	// Minutes and seconds entry check
	function automatic logic ms_ok(input logic [6:0] v);
		return bcd_ok({1'h0, v}) && (v <= 7'h59);
	endfunction

	// Convert an entered hour to the 24-hour counter form
	function automatic logic [5:0] to24(input logic [5:0] h, input logic pm, input logic hr12);
		logic [7:0] hb;
		hb = bcd2bin({2'h0, h});
		if (hr12) begin
			if (hb == 8'h0C)
				hb = 8'h00;
			if (pm)
				hb = hb + 8'h0C;
		end
		return 6'(bin2bcd(hb));
	endfunction

	// Time or time-alarm word check
	function automatic logic time_ok(input logic [31:0] w, input logic hr12);
		return ms_ok(w[6:0]) && ms_ok(w[14:8])
			&& hour_ok(w[21:16], w[bcc_pkg::TIM_PM], hr12);
	endfunction

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		logic edge_seen;
		logic tick;
		logic run_tim;
		logic sec_wrap;
		logic min_wrap;
		logic hour_wrap;
		logic day_roll;
		logic month_end;
		logic year_end;
		logic [bcc_pkg::ST_W-1:0] set_v;
		logic [bcc_pkg::ST_W-1:0] clr_v;
		logic wr_ok;
		logic match;
		logic any_en;
		logic [31:0] w;
		logic [7:0] cb;
		edge_seen = 1'b0;
		tick = 1'b0;
		run_tim = 1'b0;
		sec_wrap = 1'b0;
		min_wrap = 1'b0;
		hour_wrap = 1'b0;
		day_roll = 1'b0;
		month_end = 1'b0;
		year_end = 1'b0;
		set_v = '0;
		clr_v = '0;
		wr_ok = 1'b0;
		match = 1'b0;
		any_en = 1'b0;
		w = reg_wdata;
		cb = 8'h00;
		state_next = state_reg;

		// Slow clock synchroniser and one-second divider
		state_next.slk = {state_reg.slk[1:0], slow_ref_clock};
		edge_seen = state_reg.slk[1] && !state_reg.slk[2];
		tick = edge_seen && (state_reg.div == CW'(TICKS_PER_SEC - 1));
		if (edge_seen)
			state_next.div = tick ? '0 : state_reg.div + CW'(1);
		state_next.tick_d = tick;

		// Second event and update acknowledge
		if (tick) begin
			set_v[bcc_pkg::ST_SEC] = 1'b1;
			if (state_reg.upd_tim || state_reg.upd_cal)
				set_v[bcc_pkg::ST_ACK] = 1'b1;
		end

		// Time counters halt only on a time update request
		run_tim = tick && !state_reg.upd_tim;
		sec_wrap = state_reg.sec == 7'h59;
		min_wrap = sec_wrap && (state_reg.min == 7'h59);
		hour_wrap = min_wrap && (state_reg.hour == 6'h23);
		if (run_tim) begin
			state_next.sec = sec_wrap ? 7'h00 : 7'(bin2bcd(bcd2bin({1'h0, state_reg.sec}) + 8'h01));
			if (sec_wrap)
				state_next.min = min_wrap ? 7'h00 : 7'(bin2bcd(bcd2bin({1'h0, state_reg.min}) + 8'h01));
			if (min_wrap)
				state_next.hour = hour_wrap ? 6'h00 : 6'(bin2bcd(bcd2bin({2'h0, state_reg.hour}) + 8'h01));
			// Time event selection
			unique case (state_reg.tev_sel)
				2'h0: set_v[bcc_pkg::ST_TEV] = sec_wrap;
				2'h1: set_v[bcc_pkg::ST_TEV] = min_wrap;
				2'h2: set_v[bcc_pkg::ST_TEV] = hour_wrap;
				2'h3: set_v[bcc_pkg::ST_TEV] = min_wrap && (state_reg.hour == 6'h11);
			endcase
		end

		// Calendar carry, halted on a calendar update request
		day_roll = run_tim && hour_wrap && !state_reg.upd_cal;
		cb = bcd2bin({2'h0, state_reg.date});
		month_end = cb == days_in(bcd2bin({3'h0, state_reg.month}), bcd2bin(state_reg.year));
		year_end = month_end && (state_reg.month == 5'h12);
		if (day_roll) begin
			state_next.day = (state_reg.day == 3'h7) ? 3'h1 : state_reg.day + 3'h1;
			state_next.date = month_end ? 6'h01 : 6'(bin2bcd(cb + 8'h01));
			if (month_end)
				state_next.month = year_end ? 5'h01 : 5'(bin2bcd(bcd2bin({3'h0, state_reg.month}) + 8'h01));
			if (year_end) begin
				state_next.year = (state_reg.year == 8'h99) ? 8'h00 : bin2bcd(bcd2bin(state_reg.year) + 8'h01);
				if (state_reg.year == 8'h99)
					state_next.cent = 7'(bin2bcd(bcd2bin({1'h0, state_reg.cent}) + 8'h01));
			end
			// Calendar event selection
			unique case (state_reg.cev_sel)
				2'h0: set_v[bcc_pkg::ST_CEV] = state_reg.day == 3'h7;
				2'h1: set_v[bcc_pkg::ST_CEV] = month_end;
				default: set_v[bcc_pkg::ST_CEV] = year_end;
			endcase
		end

		// Alarm compare on the cycle after the counters move
		any_en = state_reg.talarm[bcc_pkg::TAL_SEC_EN] || state_reg.talarm[bcc_pkg::TAL_MIN_EN]
			|| state_reg.talarm[bcc_pkg::TAL_HOUR_EN] || state_reg.calarm[bcc_pkg::CAL_MTH_EN]
			|| state_reg.calarm[bcc_pkg::CAL_DATE_EN];
		match = (!state_reg.talarm[bcc_pkg::TAL_SEC_EN] || state_reg.talarm[6:0] == state_reg.sec)
			&& (!state_reg.talarm[bcc_pkg::TAL_MIN_EN] || state_reg.talarm[14:8] == state_reg.min)
			&& (!state_reg.talarm[bcc_pkg::TAL_HOUR_EN] || state_reg.talarm[21:16] == state_reg.hour)
			&& (!state_reg.calarm[bcc_pkg::CAL_MTH_EN] || state_reg.calarm[20:16] == state_reg.month)
			&& (!state_reg.calarm[bcc_pkg::CAL_DATE_EN] || state_reg.calarm[29:24] == state_reg.date);
		set_v[bcc_pkg::ST_ALARM] = state_reg.tick_d && any_en && match;

		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				bcc_pkg::OFS_CONTROL: begin
					state_next.upd_tim = w[bcc_pkg::CTL_UPD_TIM];
					state_next.upd_cal = w[bcc_pkg::CTL_UPD_CAL];
					state_next.tev_sel = w[bcc_pkg::CTL_TEV_LO +: 2];
					state_next.cev_sel = w[bcc_pkg::CTL_CEV_LO +: 2];
				end
				bcc_pkg::OFS_MODE: state_next.hr12 = w[bcc_pkg::MODE_HR12];
				bcc_pkg::OFS_TIME: begin
					// Write lands only while the time counters are stopped
					if (state_reg.upd_tim) begin
						wr_ok = time_ok(w, state_reg.hr12);
						state_next.verr[bcc_pkg::VE_TIME] = !wr_ok;
						if (wr_ok) begin
							state_next.sec = w[6:0];
							state_next.min = w[bcc_pkg::TIM_MIN_LO +: 7];
							state_next.hour = to24(w[bcc_pkg::TIM_HOUR_LO +: 6], w[bcc_pkg::TIM_PM], state_reg.hr12);
						end
					end
				end
				bcc_pkg::OFS_CAL: begin
					if (state_reg.upd_cal) begin
						cb = bcd2bin({3'h0, w[bcc_pkg::CAL_MONTH_LO +: 5]});
						wr_ok = (w[6:0] == 7'h19 || w[6:0] == 7'h20)
							&& bcd_ok(w[bcc_pkg::CAL_YEAR_LO +: 8])
							&& bcd_ok({3'h0, w[bcc_pkg::CAL_MONTH_LO +: 5]})
							&& cb >= 8'h01 && cb <= 8'h0C
							&& w[bcc_pkg::CAL_DAY_LO +: 3] != 3'h0
							&& bcd_ok({2'h0, w[bcc_pkg::CAL_DATE_LO +: 6]})
							&& w[bcc_pkg::CAL_DATE_LO +: 6] != 6'h00
							&& bcd2bin({2'h0, w[bcc_pkg::CAL_DATE_LO +: 6]})
							<= days_in(cb, bcd2bin(w[bcc_pkg::CAL_YEAR_LO +: 8]));
						state_next.verr[bcc_pkg::VE_CAL] = !wr_ok;
						if (wr_ok) begin
							state_next.cent = w[6:0];
							state_next.year = w[bcc_pkg::CAL_YEAR_LO +: 8];
							state_next.month = w[bcc_pkg::CAL_MONTH_LO +: 5];
							state_next.day = w[bcc_pkg::CAL_DAY_LO +: 3];
							state_next.date = w[bcc_pkg::CAL_DATE_LO +: 6];
						end
					end
				end
				bcc_pkg::OFS_TALARM: begin
					wr_ok = time_ok(w, state_reg.hr12);
					state_next.verr[bcc_pkg::VE_TALARM] = !wr_ok;
					if (wr_ok)
						state_next.talarm = {8'h00, w[bcc_pkg::TAL_HOUR_EN], 1'b0,
							to24(w[21:16], w[bcc_pkg::TIM_PM], state_reg.hr12), w[15:0]};
				end
				bcc_pkg::OFS_CALARM: begin
					cb = bcd2bin({3'h0, w[20:16]});
					wr_ok = bcd_ok({3'h0, w[20:16]}) && cb >= 8'h01 && cb <= 8'h0C
						&& bcd_ok({2'h0, w[29:24]}) && w[29:24] != 6'h00 && w[29:24] <= 6'h31;
					state_next.verr[bcc_pkg::VE_CALARM] = !wr_ok;
					if (wr_ok)
						state_next.calarm = w & 32'hBF9F_0000;
				end
				bcc_pkg::OFS_SCLEAR: clr_v = w[bcc_pkg::ST_W-1:0];
				bcc_pkg::OFS_IRQ_EN: state_next.mask = state_reg.mask | w[bcc_pkg::ST_W-1:0];
				bcc_pkg::OFS_IRQ_DIS: state_next.mask = state_reg.mask & ~w[bcc_pkg::ST_W-1:0];
				default: ;
			endcase
		end

		// Sticky status: a set in the clearing cycle wins
		state_next.status = (state_reg.status & ~clr_v) | set_v;

		// Read data, valid only in the cycle after the strobe
		state_next.rdata = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				bcc_pkg::OFS_CONTROL: state_next.rdata = {14'h0000, state_reg.cev_sel,
					6'h00, state_reg.tev_sel, 6'h00, state_reg.upd_cal, state_reg.upd_tim};
				bcc_pkg::OFS_MODE: state_next.rdata = {31'h0, state_reg.hr12};
				bcc_pkg::OFS_TIME: state_next.rdata = {9'h000,
					state_reg.hr12 && (state_reg.hour >= 6'h12), state_reg.hour,
					1'b0, state_reg.min, 1'b0, state_reg.sec};
				bcc_pkg::OFS_CAL: state_next.rdata = {2'h0, state_reg.date, state_reg.day,
					state_reg.month, state_reg.year, 1'b0, state_reg.cent};
				bcc_pkg::OFS_TALARM: state_next.rdata = state_reg.talarm;
				bcc_pkg::OFS_CALARM: state_next.rdata = state_reg.calarm;
				bcc_pkg::OFS_STATUS: state_next.rdata = 32'(state_reg.status);
				bcc_pkg::OFS_IRQ_MASK: state_next.rdata = 32'(state_reg.mask);
				bcc_pkg::OFS_VALIDITY: state_next.rdata = 32'(state_reg.verr);
				default: state_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg <= '0;
			state_reg.cent <= bcc_pkg::RST_CAL[6:0];
			state_reg.year <= bcc_pkg::RST_CAL[15:8];
			state_reg.month <= bcc_pkg::RST_CAL[20:16];
			state_reg.day <= bcc_pkg::RST_CAL[23:21];
			state_reg.date <= bcc_pkg::RST_CAL[29:24];
			state_reg.calarm <= bcc_pkg::RST_CALARM;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs
	assign reg_rdata = state_reg.rdata;
	assign irq = |(state_reg.status & state_reg.mask);
endmodule
`default_nettype wire

// ### tb/bcc_rtc_bench.sv
// Self-checking bench for the calendar clock register interface
`timescale 1ns/1ps
`default_nettype none
module bcc_rtc_bench;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic slow_ref_clock = 1'b0;
	logic [5:0] reg_addr = 6'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic irq;
	int errors = 0;
	int n_tests = 0;
	logic [31:0] t0;
	logic [31:0] t1;
	logic [31:0] rst_tab [12] = '{32'h0, 32'h0, 32'h0, 32'h0181_9819, 32'h0, 32'h0101_0000,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	logic [31:0] bad_tab [4] = '{32'h0000_6058, 32'h0024_5958, 32'h0040_5958, 32'h0000_595A};
	// Short second keeps the run brief
	bcc_rtc #(.TICKS_PER_SEC(4)) dut (
		.sys_clk(sys_clk),
		.srst(srst),
		.slow_ref_clock(slow_ref_clock),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.irq(irq)
	);
	// System clock and an unrelated slow clock
	always #2 sys_clk = ~sys_clk;
	always #18.5 slow_ref_clock = ~slow_ref_clock;
	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_rd(input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	task automatic st_bit(input int b, input logic v);
		logic [31:0] d;
		rd(bcc_pkg::OFS_STATUS, d);
		chk({31'h0, d[b]}, {31'h0, v});
	endtask
	// Poll a status flag with a bounded number of reads
	task automatic wait_bit(input int b);
		logic [31:0] d;
		d = 32'h0;
		for (int i = 0; i < 200 && d[b] !== 1'b1; i++) begin
			rd(bcc_pkg::OFS_STATUS, d);
		end
		chk({31'h0, d[b]}, 32'h1);
	endtask
	// Clear the second flag and wait for exactly one new second
	task automatic sec_step;
		wr(bcc_pkg::OFS_SCLEAR, 32'h4);
		wait_bit(bcc_pkg::ST_SEC);
	endtask
	function automatic logic [6:0] next_sec(input logic [6:0] s);
		return (s[3:0] == 4'h9) ? {s[6:4] + 3'h1, 4'h0} : s + 7'h01;
	endfunction
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge sys_clk);
		errors++;
		$display("[FAIL] %0t watchdog got %h exp %h", $time, 1'b0, 1'b1);
		summarize;
	end
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			chk_rd(6'(i * 4), rst_tab[i]);
		end
		chk_rd(6'h30, 32'h0);
		wr(6'h30, 32'h1);
		chk_rd(bcc_pkg::OFS_MODE, 32'h0);
		$display("test reset values done");
		wr(bcc_pkg::OFS_MODE, 32'hFFFF_FFFF);
		chk_rd(bcc_pkg::OFS_MODE, 32'h1);
		wr(bcc_pkg::OFS_MODE, 32'h0);
		wr(bcc_pkg::OFS_CONTROL, 32'h0003_0100);
		chk_rd(bcc_pkg::OFS_CONTROL, 32'h0003_0100);
		wr(bcc_pkg::OFS_CONTROL, 32'h0003_0102);
		wait_bit(bcc_pkg::ST_ACK);
		wr(bcc_pkg::OFS_CAL, 32'h3022_2420);
		chk_rd(bcc_pkg::OFS_VALIDITY, 32'h2);
		wr(bcc_pkg::OFS_CAL, 32'h2922_2421);
		chk_rd(bcc_pkg::OFS_CAL, 32'h0181_9819);
		wr(bcc_pkg::OFS_CAL, 32'h2922_2420);
		chk_rd(bcc_pkg::OFS_CAL, 32'h2922_2420);
		chk_rd(bcc_pkg::OFS_VALIDITY, 32'h0);
		sec_step;
		rd(bcc_pkg::OFS_TIME, t0);
		sec_step;
		rd(bcc_pkg::OFS_TIME, t1);
		chk(t1, {t0[31:7], next_sec(t0[6:0])});
		wr(bcc_pkg::OFS_CONTROL, 32'h0003_0100);
		wr(bcc_pkg::OFS_SCLEAR, 32'h1);
		sec_step;
		$display("test calendar update done");
		wr(bcc_pkg::OFS_CONTROL, 32'h0003_0101);
		wait_bit(bcc_pkg::ST_ACK);
		wr(bcc_pkg::OFS_TIME, 32'h0000_5958);
		chk_rd(bcc_pkg::OFS_TIME, 32'h0000_5958);
		for (int i = 0; i < 4; i++) begin
			wr(bcc_pkg::OFS_TIME, bad_tab[i]);
			chk_rd(bcc_pkg::OFS_VALIDITY, 32'h1);
			chk_rd(bcc_pkg::OFS_TIME, 32'h0000_5958);
		end
		repeat (80) @(posedge sys_clk);
		// Two reads agree while the time counters stand
		rd(bcc_pkg::OFS_TIME, t0);
		rd(bcc_pkg::OFS_TIME, t1);
		chk(t1, t0);
		chk_rd(bcc_pkg::OFS_TIME, 32'h0000_5958);
		wr(bcc_pkg::OFS_MODE, 32'h1);
		wr(bcc_pkg::OFS_TIME, 32'h0041_0000);
		chk_rd(bcc_pkg::OFS_TIME, 32'h0053_0000);
		wr(bcc_pkg::OFS_TIME, 32'h0013_0000);
		chk_rd(bcc_pkg::OFS_VALIDITY, 32'h1);
		wr(bcc_pkg::OFS_MODE, 32'h0);
		wr(bcc_pkg::OFS_TIME, 32'h0000_5958);
		chk_rd(bcc_pkg::OFS_VALIDITY, 32'h0);
		wr(bcc_pkg::OFS_CONTROL, 32'h0003_0100);
		wr(bcc_pkg::OFS_SCLEAR, 32'h9);
		sec_step;
		chk_rd(bcc_pkg::OFS_TIME, 32'h0000_5959);
		st_bit(bcc_pkg::ST_TEV, 1'b0);
		sec_step;
		chk_rd(bcc_pkg::OFS_TIME, 32'h0001_0000);
		st_bit(bcc_pkg::ST_TEV, 1'b1);
		$display("test time update done");
		wr(bcc_pkg::OFS_TALARM, 32'h0000_0082);
		wr(bcc_pkg::OFS_IRQ_EN, 32'h2);
		wr(bcc_pkg::OFS_SCLEAR, 32'h2);
		sec_step;
		st_bit(bcc_pkg::ST_ALARM, 1'b0);
		sec_step;
		st_bit(bcc_pkg::ST_ALARM, 1'b1);
		chk({31'h0, irq}, 32'h1);
		chk_rd(bcc_pkg::OFS_IRQ_MASK, 32'h2);
		wr(bcc_pkg::OFS_IRQ_DIS, 32'h2);
		#1;
		chk({31'h0, irq}, 32'h0);
		wr(bcc_pkg::OFS_SCLEAR, 32'h2);
		st_bit(bcc_pkg::ST_ALARM, 1'b0);
		wr(bcc_pkg::OFS_TALARM, 32'h0000_00E0);
		chk_rd(bcc_pkg::OFS_VALIDITY, 32'h4);
		chk_rd(bcc_pkg::OFS_TALARM, 32'h0000_0082);
		wr(bcc_pkg::OFS_CALARM, 32'h0113_0000);
		chk_rd(bcc_pkg::OFS_VALIDITY, 32'hC);
		chk_rd(bcc_pkg::OFS_CALARM, 32'h0101_0000);
		$display("test alarm done");
		// Year rollover at midnight raises the calendar event
		wr(bcc_pkg::OFS_CONTROL, 32'h0002_0003);
		wait_bit(bcc_pkg::ST_ACK);
		wr(bcc_pkg::OFS_TIME, 32'h0023_5959);
		wr(bcc_pkg::OFS_CAL, 32'h31F2_9919);
		wr(bcc_pkg::OFS_SCLEAR, 32'h1F);
		wr(bcc_pkg::OFS_CONTROL, 32'h0002_0000);
		wait_bit(bcc_pkg::ST_CEV);
		chk_rd(bcc_pkg::OFS_CAL, 32'h0121_0020);
		chk_rd(bcc_pkg::OFS_TIME, 32'h0000_0000);
		$display("test calendar event done");
		summarize;
	end
endmodule
`default_nettype wire

// ### tb/bcc_rtc_checker.sv
// Concurrent checks on the bus and interrupt ports of the calendar clock
`timescale 1ns/1ps
`default_nettype none
module bcc_rtc_checker #(
	parameter int TICKS_PER_SEC = 4
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic slow_ref_clock,
	input wire logic [5:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic irq
);
	logic [4:0] mask_reg;
	logic [4:0] mask_next;
	// ------------------------------------------------------------
	// Shadow of the interrupt mask
	// ------------------------------------------------------------
	// Set and clear strobes never share a cycle on this bus
	always_comb begin
		mask_next = mask_reg;
		if (reg_wr && reg_addr == bcc_pkg::OFS_IRQ_EN) begin
			mask_next = mask_reg | reg_wdata[4:0];
		end
		if (reg_wr && reg_addr == bcc_pkg::OFS_IRQ_DIS) begin
			mask_next = mask_reg & ~reg_wdata[4:0];
		end
	end
	// Register the shadow
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mask_reg <= 5'h00;
		end else begin
			mask_reg <= mask_next;
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	sequence s_rd(logic [5:0] a);
		reg_rd && reg_addr == a;
	endsequence
	sequence s_wr(logic [5:0] a);
		reg_wr && reg_addr == a;
	endsequence
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside read answer");
	a_reset_quiet: assert property (disable iff (1'b0) srst |=> reg_rdata == 32'h0 && !irq)
		else $error("outputs not quiet after reset");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 6'h2C |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_wo_zero: assert property (reg_rd && reg_addr inside {6'h1C, 6'h20, 6'h24}
		|=> reg_rdata == 32'h0) else $error("write-only read not zero");
	a_mode_pad: assert property (s_rd(bcc_pkg::OFS_MODE) |=> reg_rdata[31:1] == 31'h0)
		else $error("mode unused bits not zero");
	a_time_pad: assert property (s_rd(bcc_pkg::OFS_TIME) |=> (reg_rdata & 32'hFF80_8080) == 32'h0)
		else $error("time unused bits not zero");
	a_ctrl_back: assert property (s_wr(bcc_pkg::OFS_CONTROL)
		##1 !(reg_wr && reg_addr == bcc_pkg::OFS_CONTROL) ##1 s_rd(bcc_pkg::OFS_CONTROL)
		|=> reg_rdata == ($past(reg_wdata, 3) & 32'h0003_0303))
		else $error("control readback wrong");
	a_irq_masked: assert property (mask_reg == 5'h00 |-> !irq)
		else $error("interrupt while fully masked");
	a_mask_back: assert property (s_rd(bcc_pkg::OFS_IRQ_MASK) |=> reg_rdata == {27'h0,
		$past(mask_reg)}) else $error("mask readback wrong");
	a_status_pad: assert property (s_rd(bcc_pkg::OFS_STATUS) |=> reg_rdata[31:5] == 27'h0)
		else $error("status unused bits not zero");
	a_valid_pad: assert property (s_rd(bcc_pkg::OFS_VALIDITY) |=> reg_rdata[31:4] == 28'h0)
		else $error("validity unused bits not zero");
endmodule
bind bcc_rtc bcc_rtc_checker #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_checker (
	.sys_clk(sys_clk),
	.srst(srst),
	.slow_ref_clock(slow_ref_clock),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.irq(irq)
);
`default_nettype wire
